// ==== core/wdt_timer_defines.vh ====
// Summary of operation
// - Counter is 16 bits, counting up on prescaled ticks.
// - Input clock is system clock divided by 12, one per machine cycle.
// - Prescale bit 0 gives divide by 2, 1 gives divide by 128, both modes.
// - Watchdog start accepted only with timer mode bit clear.
// - Start clears low byte, then loads reload byte to high byte one cycle later.
// - Reload byte writable except in the watchdog overflow cycle; loaded on start, refresh, timer run, timer overflow, kept reset.
// - Counter bytes are read-only; writes do nothing.
// - Running watchdog cannot be stopped; mode bit changes ignored.
// - Refresh needs arm bit then start bit on the very next instruction.
// - Arm bit clears itself three machine cycles after being set.
// - Refresh clears low byte and loads high byte from reload byte.
// - Watchdog overflow past ffff issues internal reset.
// - System reset clears reload, refresh, control bits and counter.
// - Watchdog reset keeps start and keep bits, sets reset-cause flag.
// - Counter restarts after watchdog reset; keep bit decides reload/prescale.
// - Off in power-down; idle freezes watchdog mode, timer mode runs.
// - Peripheral save bit ignored in watchdog mode, freezes timer mode.
// - Period is 2^(1+6*prescale)*(65536-reload*256) machine cycles.
// - Timer mode bit settable only before watchdog start.
// - Timer run clears overflow flag, loads reload, starts counting.
// - Timer overflow sets overflow flag and irq source, no reset.
// - Timer overflow requests irq if enabled; reloads; run clear stops.
// - Mode bit writes ignored while running unless run cleared same write.
`ifndef WDT_TIMER_DEFINES_VH
`define WDT_TIMER_DEFINES_VH
`define WDT_SYS_DIV 4'hc
`define WDT_PRE_SHORT 7'h01
`define WDT_PRE_LONG 7'h7f
`define WDT_ARM_CYCLES 2'h3
`define WDT_RST_PULSE 4'h8
`define WDT_RESET_BYTE 8'h00
`define WDT_RESET_COUNT 16'h0000
`endif

// ==== core/machine_cycle_gen.v ====
`timescale 1ns/1ps
`include "wdt_timer_defines.vh"
module machine_cycle_gen (
  input wire clk, // System clock
  input wire resetn, // Async reset, active low
  output reg cycleTick // One pulse per machine cycle
);
  reg [3:0] divCount;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCount <= 4'h0;
      cycleTick <= 1'b0;
    end else begin
      cycleTick <= (divCount == `WDT_SYS_DIV - 4'h1);
      if (divCount == `WDT_SYS_DIV - 4'h1)
        divCount <= 4'h0;
      else
        divCount <= divCount + 4'h1;
    end
  end
endmodule

// ==== core/wdt_prescaler.v ====
`timescale 1ns/1ps
`include "wdt_timer_defines.vh"
module wdt_prescaler (
  input wire clk, // System clock
  input wire resetn, // Async reset, active low
  input wire clear, // Restart prescaler phase
  input wire cycleTick, // Machine cycle pulse
  input wire advance, // Counting allowed
  input wire longDiv, // 0 divide by 2, 1 divide by 128
  output wire countTick // One-cycle tick to the counter
);
  reg [6:0] preCount;
  wire [6:0] limit = longDiv ? `WDT_PRE_LONG : `WDT_PRE_SHORT;
  assign countTick = cycleTick && advance && (preCount >= limit);
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      preCount <= 7'h00;
    else if (clear)
      preCount <= 7'h00;
    else if (cycleTick && advance) begin
      if (preCount >= limit)
        preCount <= 7'h00;
      else
        preCount <= preCount + 7'h01;
    end
  end
endmodule

// ==== core/watchdog_timer_with_timer_mode.v ====
`timescale 1ns/1ps
`include "wdt_timer_defines.vh"
module watchdog_timer_with_timer_mode (
  input wire clk, // System clock, 25 MHz
  input wire resetn, // System reset, async, active low
  input wire relWrite, // Pulse: write reload byte
  input wire [7:0] relData, // Reload byte data
  input wire ctrlWrite, // Pulse: write control bits below
  input wire startBit, // Watchdog start bit value
  input wire keepBit, // Keep configuration bit value
  input wire prescaleBit, // Prescale select value
  input wire modeBit, // Timer mode select value
  input wire runBit, // Timer run bit value
  input wire armWrite, // Pulse: write refresh-arm bit as 1
  input wire ovfClear, // Pulse: clear timer overflow flag
  input wire srcClear, // Pulse: clear timer irq source
  input wire counterWrite, // Pulse: write to counter bytes, ignored
  input wire instrEnd, // Pulse: an instruction completed
  input wire timerIrqEnable, // Timer interrupt enable
  input wire idleMode, // Idle mode active
  input wire powerDown, // Power-down mode active
  input wire peripheralSaveBit, // Peripheral power save bit
  output reg [7:0] reloadByte, // Reload byte readback
  output wire [7:0] countHigh, // Counter high byte
  output wire [7:0] countLow, // Counter low byte
  output reg wdtRunning, // Watchdog start bit readback
  output reg keepConfig, // Keep configuration readback
  output reg prescaleSel, // Prescale select readback
  output reg timerMode, // Timer mode select readback
  output reg timerRun, // Timer run readback
  output reg refreshArm, // Refresh-arm readback
  output reg resetCause, // Set after a watchdog reset
  output reg timerOverflowFlag, // Timer overflow flag
  output reg timerIrqSource, // Central timer irq source bit
  output wire timerIrq, // Timer interrupt request
  output reg wdtResetn // Internal watchdog reset, active low
);
  reg [15:0] count;
  reg loadPending;
  reg [1:0] armAge;
  reg armSeenEnd;
  reg [3:0] rstCount;
  reg inWdtReset;
  wire cycleTick;
  wire countTick;
  assign countHigh = count[15:8];
  assign countLow = count[7:0];
  assign timerIrq = timerIrqSource && timerIrqEnable;
  // Watchdog-mode clocking ignores the save bit; timer mode honours it
  wire wdtAdvance = wdtRunning && !timerMode && !idleMode && !powerDown && !inWdtReset;
  wire tmrAdvance = timerRun && timerMode && !powerDown && !peripheralSaveBit;
  wire advance = wdtAdvance || tmrAdvance;
  // Start write with arm still valid is a refresh, not a fresh start
  wire startReq = ctrlWrite && startBit && !timerMode && !modeBit;
  wire isRefresh = startReq && wdtRunning && refreshArm && !armSeenEnd;
  wire isStart = startReq && !wdtRunning;
  wire runStart = ctrlWrite && runBit && !timerRun && timerMode;
  wire overflow = countTick && (count == 16'hffff);
  wire wdtOverflow = overflow && !timerMode;
  wire tmrOverflow = overflow && timerMode;
  machine_cycle_gen i_machine_cycle_gen (
    .clk(clk),
    .resetn(resetn),
    .cycleTick(cycleTick)
  );
  wdt_prescaler i_wdt_prescaler (
    .clk(clk),
    .resetn(resetn),
    .clear(isStart || isRefresh || runStart || inWdtReset),
    .cycleTick(cycleTick),
    .advance(advance),
    .longDiv(prescaleSel),
    .countTick(countTick)
  );
  // Control and configuration bits
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reloadByte <= `WDT_RESET_BYTE;
      wdtRunning <= 1'b0;
      keepConfig <= 1'b0;
      prescaleSel <= 1'b0;
      timerMode <= 1'b0;
      timerRun <= 1'b0;
    end else if (wdtOverflow) begin
      if (!keepConfig) begin
        reloadByte <= `WDT_RESET_BYTE;
        prescaleSel <= 1'b0;
      end
      timerRun <= 1'b0;
    end else begin
      if (relWrite)
        reloadByte <= relData;
      if (ctrlWrite) begin
        prescaleSel <= prescaleBit;
        if (!wdtRunning)
          keepConfig <= keepBit;
        if (isStart)
          wdtRunning <= 1'b1;
        if (!wdtRunning && (!timerRun || !runBit))
          timerMode <= modeBit;
        if (timerMode && !wdtRunning)
          timerRun <= runBit;
        else
          timerRun <= 1'b0;
      end
    end
  end
  // Refresh-arm window: cleared after three machine cycles
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refreshArm <= 1'b0;
      armAge <= 2'h0;
      armSeenEnd <= 1'b0;
    end else if (armWrite) begin
      refreshArm <= 1'b1;
      armAge <= 2'h0;
      armSeenEnd <= 1'b0;
    end else if (refreshArm) begin
      // Arming instruction ends with its own write; any later end without a start write kills it
      if (instrEnd && !(ctrlWrite && startBit))
        armSeenEnd <= 1'b1;
      if (isRefresh)
        refreshArm <= 1'b0;
      else if (cycleTick) begin
        if (armAge == `WDT_ARM_CYCLES - 2'h1)
          refreshArm <= 1'b0;
        armAge <= armAge + 2'h1;
      end
    end
  end
  // Counter; no path from counterWrite reaches it
  reg [15:0] next_count;
  reg next_loadPending;
  function [15:0] reloadValue;
    input [7:0] rel;
    begin
      reloadValue = {rel, 8'h00};
    end
  endfunction
  always @* begin
    next_count = count;
    next_loadPending = loadPending;
    if (wdtOverflow) begin
      next_count = `WDT_RESET_COUNT;
      next_loadPending = 1'b1;
    end else if (isStart || isRefresh || runStart) begin
      next_loadPending = 1'b1;
      next_count[7:0] = 8'h00;
    end else if (loadPending && !inWdtReset) begin
      next_count = reloadValue(reloadByte);
      next_loadPending = 1'b0;
    end else if (tmrOverflow) begin
      next_count = reloadValue(reloadByte);
    end else if (countTick) begin
      next_count = count + 16'h0001;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= `WDT_RESET_COUNT;
      loadPending <= 1'b0;
    end else begin
      count <= next_count;
      loadPending <= next_loadPending;
    end
  end
  // Flags: hardware set beats software clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerOverflowFlag <= 1'b0;
      timerIrqSource <= 1'b0;
      resetCause <= 1'b0;
    end else begin
      if (tmrOverflow)
        timerOverflowFlag <= 1'b1;
      else if (runStart || ovfClear)
        timerOverflowFlag <= 1'b0;
      if (tmrOverflow)
        timerIrqSource <= 1'b1;
      else if (srcClear)
        timerIrqSource <= 1'b0;
      if (wdtOverflow)
        resetCause <= 1'b1;
    end
  end
  // Reset pulse long enough for the rest of the chip
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstCount <= 4'h0;
      inWdtReset <= 1'b0;
      wdtResetn <= 1'b1;
    end else if (wdtOverflow) begin
      rstCount <= `WDT_RST_PULSE - 4'h1;
      inWdtReset <= 1'b1;
      wdtResetn <= 1'b0;
    end else if (inWdtReset) begin
      if (rstCount == 4'h0) begin
        inWdtReset <= 1'b0;
        wdtResetn <= 1'b1;
      end else
        rstCount <= rstCount - 4'h1;
    end
  end
endmodule

// ==== verif/watchdog_timer_chk.sv ====
`timescale 1ns/1ps
module watchdog_timer_chk (
  input wire clk, resetn, ctrlWrite, startBit, modeBit, powerDown, timerIrqEnable, // Inputs
  input wire [7:0] countHigh, countLow, reloadByte, // Count and reload
  input wire wdtRunning, timerMode, refreshArm, resetCause, timerOverflowFlag, // Status
  input wire timerIrqSource, timerIrq, wdtResetn // Events
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_pulse_len: assert property ($fell(wdtResetn) |-> !wdtResetn [*7] ##[1:2] wdtResetn)
    else $error("watchdog reset pulse length wrong");
  a_cause_set: assert property ($fell(wdtResetn) |-> resetCause)
    else $error("reset cause not set");
  a_irq_gate: assert property (timerIrq == (timerIrqSource && timerIrqEnable))
    else $error("irq request not gated by enable");
  a_arm_expiry: assert property ($rose(refreshArm) |-> ##[1:37] !refreshArm)
    else $error("refresh arm did not expire");
  a_timer_norst: assert property (timerMode |-> wdtResetn)
    else $error("reset issued in timer mode");
  a_mode_lock: assert property (wdtRunning && $past(wdtRunning) |-> $stable(timerMode))
    else $error("mode changed while running");
  a_start_load: assert property (ctrlWrite && startBit && !modeBit && !timerMode && !wdtRunning
    && !powerDown |=> countLow == 8'h00 ##1 countHigh == reloadByte)
    else $error("start did not load counter");
  a_pd_freeze: assert property (powerDown && $past(powerDown) |-> $stable({countHigh, countLow}))
    else $error("counter moved in power-down");
  a_flag_src: assert property ($rose(timerOverflowFlag) |-> timerIrqSource)
    else $error("irq source not set with flag");
endmodule
bind watchdog_timer_with_timer_mode watchdog_timer_chk i_watchdog_timer_chk (.*);

// ==== verif/watchdog_timer_with_timer_mode_test.sv ====
`timescale 1ns/1ps
module watchdog_timer_with_timer_mode_test;
  reg clk = 0, resetn = 0, relWrite = 0, ctrlWrite = 0, startBit = 0, keepBit = 0;
  reg prescaleBit = 0, modeBit = 0, runBit = 0, armWrite = 0, ovfClear = 0, srcClear = 0;
  reg counterWrite = 0, instrEnd = 0, timerIrqEnable = 0, idleMode = 0, powerDown = 0;
  reg peripheralSaveBit = 0;
  reg [7:0] relData = 8'hff;
  wire [7:0] reloadByte, countHigh, countLow;
  wire wdtRunning, keepConfig, prescaleSel, timerMode, timerRun, refreshArm, resetCause;
  wire timerOverflowFlag, timerIrqSource, timerIrq, wdtResetn;
  integer err_count = 0, checked = 0, n;
  reg [15:0] snap;
  always #20 clk = ~clk;
  watchdog_timer_with_timer_mode i_watchdog_timer_with_timer_mode (.*);
  task give_verdict;
    begin
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task check(input [23:0] seen, input [23:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        err_count = err_count + 1;
        $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  // Write pulse, then let the readback settle
  task ctl(input [4:0] v);
    begin
      @(posedge clk);
      ctrlWrite <= 1'b1;
      {startBit, keepBit, prescaleBit, modeBit, runBit} <= v;
      @(posedge clk);
      ctrlWrite <= 1'b0;
      cyc(2);
    end
  endtask
  task pul(input [5:0] v);
    begin
      @(posedge clk);
      {relWrite, armWrite, instrEnd, counterWrite, ovfClear, srcClear} <= v;
      @(posedge clk);
      {relWrite, armWrite, instrEnd, counterWrite, ovfClear, srcClear} <= 6'h00;
      cyc(1);
    end
  endtask
  // Bounded wait; sel picks the timer flag, else the watchdog reset
  task waitEvt(input sel);
    begin
      n = 0;
      while ((sel ? timerOverflowFlag : !wdtResetn) !== 1'b1 && n < 8000) begin
        cyc(1);
        n = n + 1;
      end
      if (n == 8000) begin
        err_count = err_count + 1;
        give_verdict;
      end
    end
  endtask
  task doReset;
    begin
      resetn <= 1'b0;
      cyc(20);
      @(posedge clk);
      resetn <= 1'b1;
      cyc(1);
      check({reloadByte, countHigh}, 16'h0000);
      check({countLow, wdtRunning, timerMode, timerRun, resetCause, wdtResetn}, 16'h0001);
    end
  endtask
  task scenWatchdog;
    begin
      pul(6'b100100);
      check({reloadByte, countHigh, countLow}, 24'hff0000);
      ctl(5'b10000);
      check({countHigh, countLow}, 16'hff00);
      ctl(5'b10010);
      check({wdtRunning, timerMode}, 2'b10);
      @(posedge clk) powerDown <= 1'b1;
      cyc(2);
      snap = {countHigh, countLow};
      cyc(60);
      check({countHigh, countLow}, snap);
      @(posedge clk) powerDown <= 1'b0;
      peripheralSaveBit <= 1'b1;
      cyc(1200);
      pul(6'b011000);
      pul(6'b001000);
      ctl(5'b10000);
      check(countLow == 8'h00, 0);
      pul(6'b011000);
      ctl(5'b10000);
      check({countHigh, countLow}, 16'hff00);
      waitEvt(1'b0);
      cyc(10);
      check({resetCause, wdtRunning, prescaleSel, reloadByte}, {3'b110, 8'h00});
      pul(6'b011000);
      ctl(5'b10000);
      check({countHigh, countLow, wdtResetn}, {16'h0000, 1'b1});
    end
  endtask
  task scenTimer;
    begin
      pul(6'b100000);
      ctl(5'b00010);
      ctl(5'b00011);
      check({timerMode, timerRun, timerOverflowFlag}, 3'b110);
      @(posedge clk) timerIrqEnable <= 1'b1;
      waitEvt(1'b1);
      check({timerIrqSource, timerIrq, resetCause, wdtResetn, timerRun}, 5'b11011);
      pul(6'b000010);
      check({timerOverflowFlag, timerIrqSource}, 2'b01);
      pul(6'b000001);
      check(timerIrq, 0);
      ctl(5'b00001);
      check(timerMode, 1);
      ctl(5'b00000);
      check({timerMode, timerRun}, 2'b00);
      // Long divide: first tick needs 128 machine cycles after run start
      ctl(5'b00110);
      ctl(5'b00111);
      @(posedge clk) idleMode <= 1'b1;
      check({countHigh, countLow}, 16'hff00);
      cyc(1500);
      check({countHigh, countLow}, 16'hff00);
      cyc(60);
      check({countHigh, countLow}, 16'hff01);
      @(posedge clk) idleMode <= 1'b0;
    end
  endtask
  initial begin
    doReset;
    scenWatchdog;
    peripheralSaveBit <= 1'b0;
    doReset;
    scenTimer;
    give_verdict;
  end
endmodule
